// ==== design/umic_pkg.sv ====
// ****************************************************************
// Shared constants for the interrupt controller
// ****************************************************************
package umic_pkg;
    // Register offsets
    localparam logic [7:0] UMIC_OFS_P0_EN = 8'h04;
    localparam logic [7:0] UMIC_OFS_P1_EN = 8'h05;
    localparam logic [7:0] UMIC_OFS_P0_POL = 8'h06;
    localparam logic [7:0] UMIC_OFS_GLB_EN = 8'h20;
    localparam logic [7:0] UMIC_OFS_EP_EN = 8'h21;
    localparam logic [7:0] UMIC_OFS_STATUS = 8'h22;
    localparam logic [7:0] UMIC_OFS_MODE = 8'h23;
    localparam logic [7:0] UMIC_RESET_VAL = 8'h00;
    // Global enable bit positions
    localparam int UMIC_GB_BUS = 0;
    localparam int UMIC_GB_T128 = 1;
    localparam int UMIC_GB_T1MS = 2;
    localparam int UMIC_GB_GPIO = 6;
    localparam int UMIC_GB_WAKE = 7;
    localparam logic [7:0] UMIC_GLB_MASK = 8'hc7;
    // Endpoint enable bit positions
    localparam int UMIC_EB_CTL = 0;
    localparam int UMIC_EB_DATA = 1;
    localparam logic [7:0] UMIC_EP_MASK = 8'h03;
    localparam logic [7:0] UMIC_P1_MASK = 8'h03;
    // Vector addresses
    localparam logic [15:0] UMIC_VEC_RESET = 16'h0000;
    localparam logic [15:0] UMIC_VEC_BUS = 16'h0002;
    localparam logic [15:0] UMIC_VEC_T128 = 16'h0004;
    localparam logic [15:0] UMIC_VEC_T1MS = 16'h0006;
    localparam logic [15:0] UMIC_VEC_CTL = 16'h0008;
    localparam logic [15:0] UMIC_VEC_DATA = 16'h000a;
    localparam logic [15:0] UMIC_VEC_GPIO = 16'h0014;
    localparam logic [15:0] UMIC_VEC_WAKE = 16'h0016;
    // Service timing in CPU cycles
    localparam int UMIC_CALL_CYC = 10;
    localparam int UMIC_JUMP_CYC = 5;
    // Timer periods
    localparam int UMIC_CLK_MHZ = 100;
    localparam int UMIC_T128_US = 128;
    localparam int UMIC_T128_CYC = UMIC_T128_US * UMIC_CLK_MHZ;
    localparam int UMIC_T1MS_NS = 1024000;
    localparam int UMIC_T1MS_CYC = UMIC_T1MS_NS / 10;
    localparam int UMIC_T1MS_TICKS = UMIC_T1MS_CYC / UMIC_T128_CYC;
    localparam int UMIC_BUS_TICKS = 2;
    localparam int UMIC_NSRC = 7;
endpackage : umic_pkg

// ==== design/umic_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module umic_top
    import umic_pkg::*;
#(
    parameter int P1_PINS = 2,
    parameter int T128_CYC = UMIC_T128_CYC,
    parameter int WAKE_TICKS = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // GPIO pins
    input wire logic [7:0] first_gpio_port,
    input wire logic [P1_PINS-1:0] second_gpio_port,
    // Bus event inputs
    input wire logic usb_se0,
    input wire logic ps2_data_line,
    // Endpoint events from the serial interface engine
    input wire logic control_endpoint_event,
    input wire logic data_endpoint_event,
    // CPU side
    input wire logic instr_done,
    input wire logic cpu_ei,
    input wire logic cpu_di,
    output logic cpu_irq_en,
    output logic service_call,
    output logic [15:0] vector_addr,
    output logic dev_addr_clear,
    output logic [7:0] latency_cyc
);
    localparam int NPIN = 8 + P1_PINS;

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] glb_en_q, ep_en_q, p0_en_q, p1_en_q, p0_pol_q, mode_q;
    logic [7:0] rdata_d;
    logic [UMIC_NSRC-1:0] pend_q;
    logic bus_mode_ps2;
    assign bus_mode_ps2 = mode_q[0];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            glb_en_q <= UMIC_RESET_VAL;
            ep_en_q <= UMIC_RESET_VAL;
            p0_en_q <= UMIC_RESET_VAL;
            p1_en_q <= UMIC_RESET_VAL;
            p0_pol_q <= UMIC_RESET_VAL;
            mode_q <= UMIC_RESET_VAL;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                UMIC_OFS_GLB_EN: glb_en_q <= reg_wdata & UMIC_GLB_MASK;
                UMIC_OFS_EP_EN: ep_en_q <= reg_wdata & UMIC_EP_MASK;
                UMIC_OFS_P0_EN: p0_en_q <= reg_wdata;
                UMIC_OFS_P1_EN: p1_en_q <= reg_wdata & UMIC_P1_MASK;
                UMIC_OFS_P0_POL: p0_pol_q <= reg_wdata;
                UMIC_OFS_MODE: mode_q <= {7'h00, reg_wdata[0]};
                default: ;
            endcase
        end
    end

    // Readback; pin enables and polarity are write-only and read zero
    always_comb begin
        case (reg_addr)
            UMIC_OFS_GLB_EN: rdata_d = glb_en_q;
            UMIC_OFS_EP_EN: rdata_d = ep_en_q;
            UMIC_OFS_STATUS: rdata_d = {1'b0, pend_q};
            UMIC_OFS_MODE: rdata_d = mode_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
        end
    end

    // ****************************************************************
    // Free-running timer
    // ****************************************************************
    logic [$clog2(T128_CYC)-1:0] pre_q;
    logic [3:0] t1_q;
    logic tick128, tick1ms;
    assign tick128 = (pre_q == $bits(pre_q)'(T128_CYC - 1));
    assign tick1ms = tick128 && (t1_q == 4'(UMIC_T1MS_TICKS - 1));

    // 128 us base, 1.024 ms every eighth
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pre_q <= '0;
            t1_q <= 4'h0;
        end else if (clk_en) begin
            pre_q <= tick128 ? '0 : pre_q + 1'b1;
            if (tick128) begin
                t1_q <= tick1ms ? 4'h0 : t1_q + 4'h1;
            end
        end
    end

    // ****************************************************************
    // Wake-up timer
    // ****************************************************************
    logic [$clog2(WAKE_TICKS+1)-1:0] wake_q;
    logic wake_ev;
    assign wake_ev = glb_en_q[UMIC_GB_WAKE] && tick128 &&
        (wake_q == $bits(wake_q)'(WAKE_TICKS - 1));

    // held clear while disabled, runs while enabled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_q <= '0;
        end else if (clk_en) begin
            if (!glb_en_q[UMIC_GB_WAKE] || wake_ev) begin
                wake_q <= '0;
            end else if (tick128) begin
                wake_q <= wake_q + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Bus reset / PS/2 detector
    // ****************************************************************
    logic cond;
    logic [1:0] bus_cnt_q;
    logic bus_det_q;
    logic bus_ev;
    assign cond = bus_mode_ps2 ? !ps2_data_line : usb_se0;
    // USB fires when SE0 ends, PS/2 on detection
    assign bus_ev = bus_mode_ps2 ?
        (!bus_det_q && cond && tick128 && bus_cnt_q == 2'(UMIC_BUS_TICKS - 1)) :
        (bus_det_q && !cond);

    // counted in 128 us ticks, so 128 to 256 us
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_cnt_q <= 2'h0;
            bus_det_q <= 1'b0;
        end else if (clk_en) begin
            if (!cond) begin
                bus_cnt_q <= 2'h0;
                bus_det_q <= 1'b0;
            end else if (tick128 && !bus_det_q) begin
                if (bus_cnt_q == 2'(UMIC_BUS_TICKS - 1)) begin
                    bus_det_q <= 1'b1;
                end else begin
                    bus_cnt_q <= bus_cnt_q + 2'h1;
                end
            end
        end
    end

    // address clear while the event lasts
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dev_addr_clear <= 1'b0;
        end else if (clk_en) begin
            dev_addr_clear <= bus_det_q && cond;
        end
    end

    // ****************************************************************
    // GPIO edge detection
    // ****************************************************************
    logic [NPIN-1:0] pin, pin_q, pin_en, pin_pol, trig, active;
    logic lock_q, lock_hold, gpio_ev;
    logic [NPIN-1:0] lock_pin_q;
    assign pin = {second_gpio_port, first_gpio_port};
    assign pin_en = {p1_en_q[P1_PINS-1:0], p0_en_q};
    // Port 1 polarity is fixed at zero: its pins trigger falling
    assign pin_pol = {{P1_PINS{1'b0}}, p0_pol_q};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            assign active[gi] = pin[gi] == pin_pol[gi];
            assign trig[gi] = pin_en[gi] && active[gi] && (pin_q[gi] != pin[gi]);
        end
    endgenerate

    // lock held while locked pin active and enabled
    assign lock_hold = |(lock_pin_q & active & pin_en);
    // any pin, one vector, no pin priority
    assign gpio_ev = glb_en_q[UMIC_GB_GPIO] && (|trig) && !(lock_q && lock_hold);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Track pins during reset so an idle level never reads as an edge
            pin_q <= pin;
            lock_q <= 1'b0;
            lock_pin_q <= '0;
        end else if (clk_en) begin
            pin_q <= pin;
            if (gpio_ev) begin
                lock_q <= 1'b1;
                lock_pin_q <= trig;
            end else if (!lock_hold) begin
                lock_q <= 1'b0;
                lock_pin_q <= '0;
            end
        end
    end

    // ****************************************************************
    // Pending flags and service
    // ****************************************************************
    // Index 0 is highest priority, in vector order
    logic [UMIC_NSRC-1:0] src_ev, src_en, req, clr;
    logic [15:0] vec_tab [UMIC_NSRC];
    logic take;
    logic [2:0] win;
    assign src_ev = {wake_ev, gpio_ev, data_endpoint_event, control_endpoint_event,
        tick1ms, tick128, bus_ev};
    // endpoint flags gated by endpoint enables
    assign src_en = {glb_en_q[UMIC_GB_WAKE], glb_en_q[UMIC_GB_GPIO],
        ep_en_q[UMIC_EB_DATA], ep_en_q[UMIC_EB_CTL], glb_en_q[UMIC_GB_T1MS],
        glb_en_q[UMIC_GB_T128], glb_en_q[UMIC_GB_BUS]};
    assign vec_tab = '{UMIC_VEC_BUS, UMIC_VEC_T128, UMIC_VEC_T1MS, UMIC_VEC_CTL,
        UMIC_VEC_DATA, UMIC_VEC_GPIO, UMIC_VEC_WAKE};
    assign req = pend_q & src_en;
    // only at an instruction boundary with CPU enable set
    assign take = instr_done && cpu_irq_en && (|req);

    always_comb begin
        win = 3'h0;
        for (int i = UMIC_NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                win = 3'(i);
            end
        end
        clr = '0;
        if (take) begin
            clr[win] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_q <= '0;
        end else if (clk_en) begin
            pend_q <= (pend_q & ~clr) | src_ev;
        end
    end

    // CPU enable cleared on service; EI and DI steer it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_irq_en <= 1'b0;
        end else if (clk_en) begin
            if (take || cpu_di) begin
                cpu_irq_en <= 1'b0;
            end else if (cpu_ei) begin
                cpu_irq_en <= 1'b1;
            end
        end
    end

    // call strobe, vector and fixed latency part
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            service_call <= 1'b0;
            vector_addr <= UMIC_VEC_RESET;
            latency_cyc <= 8'h00;
        end else if (clk_en) begin
            service_call <= take;
            if (take) begin
                vector_addr <= vec_tab[win];
                latency_cyc <= 8'(UMIC_CALL_CYC + UMIC_JUMP_CYC);
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_reset_vec;
        @(posedge ref_clk) $fell(rst) |-> vector_addr == UMIC_VEC_RESET;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector not zero");

    property p_call_clears_en;
        @(posedge ref_clk) disable iff (rst) (clk_en && take) |=> !cpu_irq_en && service_call;
    endproperty
    a_call_clears_en: assert property (p_call_clears_en) else $error("service sequence");

    property p_bus_first;
        @(posedge ref_clk) disable iff (rst)
            (clk_en && take && req[0]) |=> vector_addr == UMIC_VEC_BUS;
    endproperty
    a_bus_first: assert property (p_bus_first) else $error("bus not highest");

    property p_boundary;
        @(posedge ref_clk) disable iff (rst) (clk_en && !instr_done) |=> !service_call;
    endproperty
    a_boundary: assert property (p_boundary) else $error("call mid instruction");

    property p_latency;
        @(posedge ref_clk) disable iff (rst) service_call |-> latency_cyc == 8'd15;
    endproperty
    a_latency: assert property (p_latency) else $error("latency wrong");

    property p_wake_off;
        @(posedge ref_clk) disable iff (rst) (clk_en && !glb_en_q[UMIC_GB_WAKE]) |=> wake_q == '0;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("wake timer ran");

    property p_gpio_gate;
        @(posedge ref_clk) disable iff (rst) gpio_ev |-> glb_en_q[UMIC_GB_GPIO] && |(trig & pin_en);
    endproperty
    a_gpio_gate: assert property (p_gpio_gate) else $error("gpio not gated");

    property p_pend_set;
        @(posedge ref_clk) disable iff (rst) (clk_en && src_ev[3]) |=> pend_q[3];
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("event lost");

    property p_di_clears;
        @(posedge ref_clk) disable iff (rst) (clk_en && cpu_di) |=> !cpu_irq_en;
    endproperty
    a_di_clears: assert property (p_di_clears) else $error("disable ignored");

    property p_addr_clear;
        @(posedge ref_clk) disable iff (rst) (clk_en && bus_det_q && cond) |=> dev_addr_clear;
    endproperty
    a_addr_clear: assert property (p_addr_clear) else $error("address not cleared");

    property p_usb_end;
        @(posedge ref_clk) disable iff (rst)
            (clk_en && !bus_mode_ps2 && bus_det_q && !cond) |=> pend_q[0];
    endproperty
    a_usb_end: assert property (p_usb_end) else $error("bus reset end lost");

    property p_glb_mask;
        @(posedge ref_clk) disable iff (rst)
            (clk_en && reg_wr && reg_addr == UMIC_OFS_GLB_EN) |=>
            glb_en_q == ($past(reg_wdata) & UMIC_GLB_MASK);
    endproperty
    a_glb_mask: assert property (p_glb_mask) else $error("global enable write");

    property p_ack_keeps_pins;
        @(posedge ref_clk) disable iff (rst)
            (clk_en && take && !reg_wr) |=> $stable(p0_en_q) && $stable(p1_en_q);
    endproperty
    a_ack_keeps_pins: assert property (p_ack_keeps_pins) else $error("pin enables moved");

    c_call: cover property (@(posedge ref_clk) service_call);
    c_gpio: cover property (@(posedge ref_clk) gpio_ev);
    c_bus: cover property (@(posedge ref_clk) bus_ev);
    c_lock: cover property (@(posedge ref_clk) lock_q && (|trig) && !gpio_ev);
endmodule : umic_top
`default_nettype wire

// ==== verification/umic_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module umic_cpu_model
    import umic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Instruction pacing
    input wire logic [3:0] instr_len,
    output logic instr_done,
    // Service observation
    input wire logic service_call,
    input wire logic [15:0] vector_addr,
    output logic [15:0] last_vec,
    output logic [7:0] boundary_err
);
    logic [3:0] phase_q;
    logic done_q;

    // ****************************************
    // Instruction pacing
    // ****************************************
    // instruction end marker; length 1 ends one every cycle
    always_ff @(posedge ref_clk) begin
        if (rst || (phase_q + 4'h1 >= instr_len)) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end
    assign instr_done = !rst && (phase_q + 4'h1 >= instr_len);

    // ****************************************
    // Call observation
    // ****************************************
    // a call may only follow a finished instruction
    always_ff @(posedge ref_clk) begin
        done_q <= instr_done;
        if (rst) begin
            boundary_err <= 8'h00;
            last_vec <= 16'h0000;
        end else if (service_call) begin
            last_vec <= vector_addr;
            if (!done_q) begin
                boundary_err <= boundary_err + 8'h01;
            end
        end
    end
endmodule : umic_cpu_model
`default_nettype wire

// ==== verification/test_usb_mcu_interrupt_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_usb_mcu_interrupt_controller
    import umic_pkg::*;
;
    logic ref_clk, rst, reg_wr, reg_rd, usb_se0, ps2_data_line, ctl_ev, dat_ev;
    logic instr_done, cpu_ei, cpu_irq_en, service_call, dev_addr_clear;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, gp0, latency_cyc, boundary_err;
    logic [15:0] vector_addr, last_vec;
    logic [3:0] instr_len;
    logic clk_en, cpu_di;
    logic [1:0] gp1;
    int error_cnt = 0;
    int check_count = 0;

    // Short tick so bus and timer counts finish quickly
    umic_top #(.P1_PINS(2), .T128_CYC(16), .WAKE_TICKS(2)) dut (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .first_gpio_port(gp0), .second_gpio_port(gp1),
        .usb_se0(usb_se0), .ps2_data_line(ps2_data_line),
        .control_endpoint_event(ctl_ev), .data_endpoint_event(dat_ev),
        .instr_done(instr_done), .cpu_ei(cpu_ei), .cpu_di(cpu_di), .cpu_irq_en(cpu_irq_en),
        .service_call(service_call), .vector_addr(vector_addr),
        .dev_addr_clear(dev_addr_clear), .latency_cyc(latency_cyc));

    umic_cpu_model cpu (
        .ref_clk(ref_clk), .rst(rst), .instr_len(instr_len), .instr_done(instr_done),
        .service_call(service_call), .vector_addr(vector_addr), .last_vec(last_vec),
        .boundary_err(boundary_err));

    // ****************************************
    // Clock and helpers
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // Fresh reset per scenario so stale pending flags never leak across
    task automatic do_reset(input logic [3:0] len);
        @(posedge ref_clk) begin
            rst <= 1'b1;
            instr_len <= len;
            gp0 <= 8'hff;
            gp1 <= 2'b11;
            usb_se0 <= 1'b0;
            ps2_data_line <= 1'b1;
        end
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
        end
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk) begin
            reg_addr <= a;
            reg_rd <= 1'b1;
        end
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, exp)
    endtask : rd_chk

    task automatic ei();
        @(posedge ref_clk) cpu_ei <= 1'b1;
        @(posedge ref_clk) cpu_ei <= 1'b0;
    endtask : ei

    task automatic di();
        @(posedge ref_clk) cpu_di <= 1'b1;
        @(posedge ref_clk) cpu_di <= 1'b0;
    endtask : di

    // Bounded wait for one call, then judge target, mask and latency
    task automatic expect_call(input logic [15:0] v, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            if (service_call === 1'b1) break;
        end
        if (i == n) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            print_verdict();
        end
        `CHK(vector_addr, v)
        `CHK(cpu_irq_en, 1'b0)
        `CHK(latency_cyc, 8'(UMIC_CALL_CYC + UMIC_JUMP_CYC))
    endtask : expect_call

    task automatic no_call(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            if (service_call !== 1'b0) seen = 1'b1;
        end
        `CHK(seen, 1'b0)
    endtask : no_call

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        do_reset(4'd1);
        `CHK(vector_addr, UMIC_VEC_RESET)
        rd_chk(UMIC_OFS_GLB_EN, 8'h00);
        rd_chk(UMIC_OFS_EP_EN, 8'h00);
        wr(UMIC_OFS_GLB_EN, 8'hff);
        rd_chk(UMIC_OFS_GLB_EN, 8'hc7);
        wr(UMIC_OFS_EP_EN, 8'hff);
        rd_chk(UMIC_OFS_EP_EN, 8'h03);
        rd_chk(8'h30, 8'h00);
        wr(UMIC_OFS_P0_EN, 8'hff);
        rd_chk(UMIC_OFS_P0_EN, 8'h00);
        // A write while frozen must not land
        @(posedge ref_clk) clk_en <= 1'b0;
        wr(UMIC_OFS_GLB_EN, 8'h00);
        @(posedge ref_clk) clk_en <= 1'b1;
        rd_chk(UMIC_OFS_GLB_EN, 8'hc7);
    endtask : t_regs

    task automatic t_timers();
        do_reset(4'd5);
        wr(UMIC_OFS_GLB_EN, 8'h02);
        // Masked across a tick: the flag must wait, then be served
        ei();
        di();
        no_call(20);
        `CHK(cpu_irq_en, 1'b0)
        ei();
        expect_call(UMIC_VEC_T128, 60);
        do_reset(4'd1);
        `CHK(vector_addr, UMIC_VEC_RESET)
        wr(UMIC_OFS_GLB_EN, 8'h04);
        ei();
        expect_call(UMIC_VEC_T1MS, 160);
    endtask : t_timers

    // Both endpoint flags pending at once: control wins, data waits
    task automatic t_endpoints();
        do_reset(4'd5);
        wr(UMIC_OFS_EP_EN, 8'h03);
        @(posedge ref_clk) begin
            ctl_ev <= 1'b1;
            dat_ev <= 1'b1;
        end
        @(posedge ref_clk) begin
            ctl_ev <= 1'b0;
            dat_ev <= 1'b0;
        end
        rd_chk(UMIC_OFS_STATUS, 8'h18);
        ei();
        expect_call(UMIC_VEC_CTL, 40);
        ei();
        expect_call(UMIC_VEC_DATA, 40);
    endtask : t_endpoints

    task automatic t_gpio();
        do_reset(4'd1);
        wr(UMIC_OFS_P0_EN, 8'h03);
        wr(UMIC_OFS_GLB_EN, 8'h40);
        ei();
        @(posedge ref_clk) gp0 <= 8'hfe;
        expect_call(UMIC_VEC_GPIO, 40);
        ei();
        @(posedge ref_clk) gp0 <= 8'hfc;
        no_call(40);
        @(posedge ref_clk) gp0 <= 8'hff;
        @(posedge ref_clk) gp0 <= 8'hfd;
        expect_call(UMIC_VEC_GPIO, 40);
        ei();
        wr(UMIC_OFS_P0_POL, 8'h01);
        @(posedge ref_clk) gp0 <= 8'hff;
        @(posedge ref_clk) gp0 <= 8'hfe;
        no_call(30);
        @(posedge ref_clk) gp0 <= 8'hff;
        expect_call(UMIC_VEC_GPIO, 40);
        ei();
        wr(UMIC_OFS_GLB_EN, 8'h00);
        @(posedge ref_clk) gp0 <= 8'hfe;
        @(posedge ref_clk) gp0 <= 8'hff;
        no_call(30);
        // Second port pin 0 shares the vector, falling edge only
        wr(UMIC_OFS_GLB_EN, 8'h40);
        wr(UMIC_OFS_P1_EN, 8'h01);
        @(posedge ref_clk) gp1 <= 2'b10;
        expect_call(UMIC_VEC_GPIO, 40);
    endtask : t_gpio

    task automatic t_bus();
        do_reset(4'd1);
        wr(UMIC_OFS_MODE, 8'h00);
        wr(UMIC_OFS_GLB_EN, 8'h01);
        ei();
        @(posedge ref_clk) usb_se0 <= 1'b1;
        repeat (10) @(posedge ref_clk);
        usb_se0 <= 1'b0;
        no_call(60);
        @(posedge ref_clk) usb_se0 <= 1'b1;
        no_call(70);
        `CHK(dev_addr_clear, 1'b1)
        @(posedge ref_clk) usb_se0 <= 1'b0;
        expect_call(UMIC_VEC_BUS, 40);
        do_reset(4'd1);
        wr(UMIC_OFS_MODE, 8'h01);
        wr(UMIC_OFS_GLB_EN, 8'h01);
        ei();
        @(posedge ref_clk) ps2_data_line <= 1'b0;
        expect_call(UMIC_VEC_BUS, 60);
        `CHK(dev_addr_clear, 1'b1)
        @(posedge ref_clk) ps2_data_line <= 1'b1;
    endtask : t_bus

    task automatic t_wake();
        do_reset(4'd1);
        wr(UMIC_OFS_GLB_EN, 8'h80);
        ei();
        expect_call(UMIC_VEC_WAKE, 120);
    endtask : t_wake

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        gp0 = 8'hff;
        usb_se0 = 1'b0;
        ps2_data_line = 1'b1;
        ctl_ev = 1'b0;
        dat_ev = 1'b0;
        cpu_ei = 1'b0;
        cpu_di = 1'b0;
        clk_en = 1'b1;
        gp1 = 2'b11;
        instr_len = 4'd1;
        t_regs();
        t_timers();
        t_endpoints();
        t_gpio();
        t_bus();
        t_wake();
        // Let the partner model see the last call before judging it
        @(posedge ref_clk);
        #1;
        `CHK(last_vec, UMIC_VEC_WAKE)
        `CHK(boundary_err, 8'h00)
        print_verdict();
    end
endmodule : test_usb_mcu_interrupt_controller
`default_nettype wire
